// File: bench/core_model.sv
// core_model: processor core side, register and table strobes
// assumes the block samples all strobes on the rising clk edge
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             tbl_wr_low,
  output logic             tbl_wr_high,
  output logic             tbl_rd,
  output logic      [23:0] tbl_addr,
  output logic      [15:0] tbl_wdata
);
  // idle bus at time zero
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {tbl_wr_low, tbl_wr_high, tbl_rd, tbl_addr, tbl_wdata} = '0;
  end
  // released data lines flip so a stale value cannot pass
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~v;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1;
    v = reg_rdata;
  endtask : rd
  // k is {read, high byte, low word}
  task automatic tw(input logic [2:0] k, input logic [23:0] a, input logic [15:0] v);
    @(posedge clk);
    {tbl_rd, tbl_wr_high, tbl_wr_low} <= k;
    tbl_addr  <= a;
    tbl_wdata <= v;
    @(posedge clk);
    {tbl_rd, tbl_wr_high, tbl_wr_low} <= 3'h0;
    tbl_wdata <= ~v;
  endtask : tw
  // key pair then start; returns on the edge that takes the start write
  task automatic go(input logic [15:0] c);
    wr(nvm_ctrl_pkg::KEY_OFS, 16'(nvm_ctrl_pkg::KEY_FIRST));
    wr(nvm_ctrl_pkg::KEY_OFS, 16'(nvm_ctrl_pkg::KEY_SECOND));
    wr(nvm_ctrl_pkg::CTRL_OFS, c | 16'h8000);
  endtask : go
endmodule : core_model
`default_nettype wire

// File: bench/nvm_program_erase_control_tb_top.sv
// nvm_program_erase_control_tb_top: random and corner runs of the nvm sequencer
// assumes core_model drives register and table ports; cycle length cut to 20
`timescale 1ns/100ps
`default_nettype none
module nvm_program_erase_control_tb_top;
  localparam int          OPC = 20;
  localparam logic [15:0] CTL = nvm_ctrl_pkg::CTRL_OFS;
  localparam logic [15:0] KEY = nvm_ctrl_pkg::KEY_OFS;
  localparam logic [15:0] ADL = nvm_ctrl_pkg::ADDR_LOW_OFS;
  logic        clk, clk_en, reset_n, reg_wr, reg_rd, tbl_wr_low, tbl_wr_high, tbl_rd;
  logic        tbl_read_unreliable, core_stall, nvm_done_flag, done_flag_clear;
  logic        master_clear_reset, watchdog_timeout, cell_start, cell_erase, cell_eeprom;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, tbl_wdata, d;
  logic [23:0] tbl_addr, cell_addr, cell_latch_data, a;
  logic [5:0]  cell_word_count;
  logic [4:0]  cell_latch_index;
  int          num_errors, checked;
  real         ts;
  // erase comes before word program in this list
  logic [15:0] codes [6] = '{16'h4041, 16'h4001, 16'h4045, 16'h4044, 16'h4004, 16'h4005};
  nvm_program_erase_control #(.OP_CYCLES(OPC)) dut_u (
    .clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tbl_wr_low, .tbl_wr_high, .tbl_rd, .tbl_addr, .tbl_wdata, .tbl_read_unreliable,
    .core_stall, .master_clear_reset, .watchdog_timeout, .nvm_done_flag, .done_flag_clear,
    .cell_start, .cell_erase, .cell_eeprom, .cell_addr, .cell_word_count,
    .cell_latch_index, .cell_latch_data);
  core_model core_u (
    .clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .tbl_wr_low,
    .tbl_wr_high, .tbl_rd, .tbl_addr, .tbl_wdata);
  // 40 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // flash row 32 words, eeprom block 16, eeprom word 1
  function automatic logic [5:0] exp_cnt(input logic [15:0] c);
    return c[2] ? (c[0] ? 6'h10 : 6'h01) : 6'h20;
  endfunction : exp_cnt
  function automatic logic [23:0] exp_adr(input logic [15:0] c, input logic [23:0] x);
    return x & ~{18'h0, c[2] ? (c[0] ? 6'h1F : 6'h01) : 6'h3F};
  endfunction : exp_adr
  // one full operation: latches, address, start, wait, completion
  task automatic run_op(input logic [15:0] c);
    logic [15:0] lo, hi;
    int          t;
    lo = 16'($urandom);
    hi = 16'($urandom);
    t = 0;
    core_u.wr(CTL, c);
    core_u.tw(3'h1, a, lo);
    core_u.tw(3'h2, a, hi);
    cell_latch_index <= c[2] ? {1'h0, a[4:1]} : a[5:1];
    repeat (2) @(posedge clk);
    #1;
    chk(cell_latch_data[15:0], lo);
    if (!c[2])
      chk(cell_latch_data[23:16], hi[7:0]);
    core_u.rd(ADL, d);
    chk(d, a[15:0]);
    core_u.rd(nvm_ctrl_pkg::ADDR_UP_OFS, d);
    chk(d, {8'h00, a[23:16]});
    core_u.go(c);
    #1;
    ts = $realtime;
    chk({cell_start, cell_erase, cell_eeprom, core_stall}, {1'h1, c[6], c[2], ~c[2]});
    chk(cell_word_count, exp_cnt(c));
    chk(cell_addr, exp_adr(c, a));
    if (c[2])
    begin
      core_u.tw(3'h4, a, 16'h0000);
      #1;
      chk(tbl_read_unreliable, 1'h1);
      core_u.wr(CTL, c);
      core_u.rd(CTL, d);
      chk(d[15], 1'h1);
    end
    while (nvm_done_flag !== 1'h1 && t < 200)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t == 200)
    begin
      num_errors++;
      return;
    end
    chk(int'(($realtime - ts) / 25.0), OPC);
    chk(core_stall, 1'h0);
    core_u.rd(CTL, d);
    chk(d[15], 1'h0);
    chk(nvm_done_flag, 1'h1);
    @(posedge clk);
    done_flag_clear <= 1'h1;
    @(posedge clk);
    done_flag_clear <= 1'h0;
    @(posedge clk);
    #1;
    chk(nvm_done_flag, 1'h0);
  endtask : run_op
  // main sequence
  initial
  begin
    {num_errors, checked} = '0;
    {reset_n, done_flag_clear, master_clear_reset, watchdog_timeout} = '0;
    {cell_latch_index, a} = '0;
    clk_en = 1'h1;
    void'($urandom(60453));
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    core_u.rd(CTL, d);
    chk(d, nvm_ctrl_pkg::CTRL_RESET);
    core_u.go(16'h4041);
    core_u.rd(CTL, d);
    chk(d[15], 1'h0);
    core_u.rd(KEY, d);
    chk(d, 16'h0000);
    core_u.rd(16'h0100, d);
    chk(d, 16'h0000);
    core_u.wr(CTL, 16'h4041);
    core_u.wr(KEY, 16'h0055);
    core_u.wr(ADL, 16'h0000);
    core_u.wr(KEY, 16'h00AA);
    core_u.wr(CTL, 16'hC141);
    core_u.rd(CTL, d);
    chk(d, 16'h4141);
    // a write while the clock enable is low must not be taken
    @(posedge clk);
    clk_en <= 1'h0;
    core_u.wr(ADL, 16'h1234);
    clk_en <= 1'h1;
    core_u.rd(ADL, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      a = {8'h00, 16'($urandom) & 16'hFFFE};
      if (codes[i][2])
        a = 24'h7FF000 | (24'($urandom) & 24'h000FFE);
      if (i == 3)
        a = nvm_ctrl_pkg::EE_LAST_ADDR;
      run_op(codes[i]);
    end
    for (int j = 1; j < 3; j++)
    begin
      core_u.wr(CTL, 16'h4004);
      core_u.go(16'h4004);
      {watchdog_timeout, master_clear_reset} <= 2'(j);
      repeat (4) @(posedge clk);
      {watchdog_timeout, master_clear_reset} <= 2'h0;
      repeat (3) @(posedge clk);
      core_u.rd(CTL, d);
      chk(d[15:13], 3'h1);
      core_u.rd(ADL, d);
      chk(d, a[15:0]);
      core_u.wr(CTL, 16'h0000);
    end
    wrap_up();
  end
endmodule : nvm_program_erase_control_tb_top
`default_nettype wire

// File: rtl/nvm_ctrl_pkg.sv
// nvm_ctrl_pkg: register map, field positions, keys and timing for the nvm control block
// assumes a 40 MHz core clock and a 16-bit register port addressed at the printed offsets
package nvm_ctrl_pkg;

  // register offsets on the core register port
  localparam logic [15:0] ADDR_LOW_OFS  = 16'h0762;
  localparam logic [15:0] ADDR_UP_OFS   = 16'h0764;
  localparam logic [15:0] CTRL_OFS      = 16'h0920;
  localparam logic [15:0] KEY_OFS       = 16'h9920;

  // control register layout and reset value
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam int          WR_BIT        = 15;
  localparam int          PERMIT_BIT    = 14;
  localparam int          ERROR_BIT     = 13;
  localparam int          TIMING_BIT    = 8;
  localparam int          OPSEL_MSB     = 6;
  localparam int          OP_ERASE_BIT  = 6;
  localparam int          OP_EEPROM_BIT = 2;
  localparam int          OP_MULTI_BIT  = 0;

  // unlock keys, in the order they must arrive
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;

  // data eeprom window in program space
  localparam logic [23:0] EE_FIRST_ADDR = 24'h7FF000;
  localparam logic [23:0] EE_LAST_ADDR  = 24'h7FFFFE;

  // operation sizes in words
  localparam logic [5:0]  ROW_WORDS     = 6'h20;
  localparam logic [5:0]  BLOCK_WORDS   = 6'h10;
  localparam logic [5:0]  SINGLE_WORD   = 6'h01;
  localparam int          LATCH_DEPTH   = 32;

  // erase or program duration
  localparam int          OP_TIME_NS    = 2000000;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_type;

endpackage : nvm_ctrl_pkg

// File: rtl/nvm_op_timer.sv
// nvm_op_timer: counts out one erase or program cycle
// assumes start and abort come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module nvm_op_timer #(
  parameter int unsigned CYCLES = 80000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE  = W'(1);

  logic [W-1:0] count_reg;

  // load on start, run down to zero; abort drops the cycle at once
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= '0;
    else if (clk_en)
    begin
      if (abort)
        count_reg <= '0;
      else if (start)
        count_reg <= LOAD;
      else if (count_reg != '0)
        count_reg <= count_reg - ONE;
    end
  end

  // done marks the last cycle; it is qualified so a frozen clock never counts it twice
  assign busy = (count_reg != '0);
  assign done = clk_en && !abort && (count_reg == ONE);

endmodule : nvm_op_timer
`default_nettype wire

// File: rtl/nvm_program_erase_control.sv
// nvm_program_erase_control: key-guarded erase/program sequencer for flash rows and eeprom
// assumes core register port and table port share clk; reset requests arrive from pins
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - program flash erases or programs one 32-word row per operation
// - start bit sets only after key writes 0x55 then 0xAA
// - core stalls while a program flash cycle runs
// - hardware clears the start bit when the cycle ends
// - 32 low-word and 32 high-byte table writes fill the 96 latch bytes
// - a high-byte latch write keeps only the low 8 source bits
// - data eeprom occupies 0x7FF000 to 0x7FFFFE of program space
// - eeprom operations cover one word or a 16-word block
// - eeprom target is upper address joined with lower address
// - an eeprom write takes about 2 ms
// - eeprom cycles run in background without stalling the core
// - eeprom reads during a cycle are flagged unreliable
// - software may set the start bit but never clear it
// - start needs write enable set earlier; enable clears at power-up
// - a reset request during a cycle sets the error bit, address kept
// - completion sets a sticky done flag until software clears it
// - eeprom block erase uses address regs and block, erase, enable bits
// - the key register is write-only and reads zero
// - address registers capture the last table access address
// - start bit is control bit 15; flash cycle nominally 2 ms
module nvm_program_erase_control #(
  parameter int unsigned OP_CYCLES = nvm_ctrl_pkg::OP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        tbl_wr_low,
  input  wire logic        tbl_wr_high,
  input  wire logic        tbl_rd,
  input  wire logic [23:0] tbl_addr,
  input  wire logic [15:0] tbl_wdata,
  output logic             tbl_read_unreliable,
  output logic             core_stall,
  input  wire logic        master_clear_reset,
  input  wire logic        watchdog_timeout,
  output logic             nvm_done_flag,
  input  wire logic        done_flag_clear,
  output logic             cell_start,
  output logic             cell_erase,
  output logic             cell_eeprom,
  output logic      [23:0] cell_addr,
  output logic      [5:0]  cell_word_count,
  input  wire logic [4:0]  cell_latch_index,
  output logic      [23:0] cell_latch_data
);

  // eeprom window decode, shared by latch indexing and read checks
  function automatic logic is_eeprom(input logic [23:0] a);
    is_eeprom = (a >= nvm_ctrl_pkg::EE_FIRST_ADDR) && (a <= nvm_ctrl_pkg::EE_LAST_ADDR);
  endfunction : is_eeprom

  // latch slot for a table address: rows hold 32 slots, eeprom blocks 16
  function automatic logic [4:0] latch_index(input logic [23:0] a);
    latch_index = is_eeprom(a) ? {1'b0, a[4:1]} : a[5:1];
  endfunction : latch_index

  logic                          wr_reg;
  logic                          permit_reg;
  logic                          error_reg;
  logic                          timing_reg;
  logic [6:0]                    opsel_reg;
  logic [15:0]                   addr_low_reg;
  logic [7:0]                    addr_up_reg;
  nvm_ctrl_pkg::key_state_type   key_state_reg;
  nvm_ctrl_pkg::key_state_type   key_state_next;
  logic                          done_flag_reg;
  logic [15:0]                   rdata_reg;
  logic                          unreliable_reg;
  logic                          cell_start_reg;
  logic                          cell_erase_reg;
  logic                          cell_eeprom_reg;
  logic [23:0]                   cell_addr_reg;
  logic [5:0]                    cell_count_reg;
  logic [23:0]                   cell_data_reg;
  logic [15:0]                   lat_low_reg [nvm_ctrl_pkg::LATCH_DEPTH];
  logic [7:0]                    lat_high_reg [nvm_ctrl_pkg::LATCH_DEPTH];
  logic [1:0]                    clear_sync_reg;
  logic [1:0]                    watchdog_sync_reg;
  logic                          reset_req;
  logic                          ctrl_wr;
  logic                          key_wr;
  logic                          start_op;
  logic                          op_done;
  logic                          op_busy;
  logic [23:0]                   target;
  logic [4:0]                    tbl_index;

  // reset requests come from pins, so both pass two flops before use
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clear_sync_reg    <= 2'h0;
      watchdog_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      clear_sync_reg    <= {clear_sync_reg[0], master_clear_reset};
      watchdog_sync_reg <= {watchdog_sync_reg[0], watchdog_timeout};
    end
  end

  assign reset_req = clear_sync_reg[1] || watchdog_sync_reg[1];
  assign ctrl_wr   = reg_wr && (reg_addr == nvm_ctrl_pkg::CTRL_OFS);
  assign key_wr    = reg_wr && (reg_addr == nvm_ctrl_pkg::KEY_OFS);
  assign target    = {addr_up_reg, addr_low_reg};
  assign tbl_index = latch_index(tbl_addr);

  // start needs the keys just before and enable set by an earlier write
  assign start_op = ctrl_wr && reg_wdata[nvm_ctrl_pkg::WR_BIT] && !wr_reg
                    && (key_state_reg == nvm_ctrl_pkg::KEY_ARMED)
                    && permit_reg && !reset_req;

  // key sequencer: any write that is not the expected next key disarms
  always_comb
  begin
    key_state_next = key_state_reg;
    if (reg_wr)
    begin
      if (key_wr && reg_wdata[7:0] == nvm_ctrl_pkg::KEY_FIRST)
        key_state_next = nvm_ctrl_pkg::KEY_GOT_FIRST;
      else if (key_wr && reg_wdata[7:0] == nvm_ctrl_pkg::KEY_SECOND
               && key_state_reg == nvm_ctrl_pkg::KEY_GOT_FIRST)
        key_state_next = nvm_ctrl_pkg::KEY_ARMED;
      else
        key_state_next = nvm_ctrl_pkg::KEY_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      key_state_reg <= nvm_ctrl_pkg::KEY_IDLE;
    else if (clk_en)
      key_state_reg <= reset_req ? nvm_ctrl_pkg::KEY_IDLE : key_state_next;
  end

  // start bit: only hardware clears it, at cycle end or on a reset request that cuts the cycle short
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wr_reg <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::WR_BIT];
    else if (clk_en)
    begin
      if (reset_req || op_done)
        wr_reg <= 1'b0;
      else if (start_op)
        wr_reg <= 1'b1;
    end
  end

  // enable may drop mid-cycle without effect; reset requests also clear it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      permit_reg <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::PERMIT_BIT];
    else if (clk_en)
    begin
      if (reset_req)
        permit_reg <= 1'b0;
      else if (ctrl_wr)
        permit_reg <= reg_wdata[nvm_ctrl_pkg::PERMIT_BIT];
    end
  end

  // operation select is frozen while a cycle runs so the cell sees one request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opsel_reg <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::OPSEL_MSB:0];
      timing_reg <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::TIMING_BIT];
    end
    else if (clk_en)
    begin
      if (reset_req)
      begin
        opsel_reg <= 7'h00;
        timing_reg <= 1'b0;
      end
      else if (ctrl_wr && !wr_reg)
      begin
        opsel_reg <= reg_wdata[nvm_ctrl_pkg::OPSEL_MSB:0];
        timing_reg <= reg_wdata[nvm_ctrl_pkg::TIMING_BIT];
      end
    end
  end

  // error bit: an interrupted cycle wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      error_reg <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::ERROR_BIT];
    else if (clk_en)
    begin
      if (reset_req && wr_reg)
        error_reg <= 1'b1;
      else if (ctrl_wr)
        error_reg <= reg_wdata[nvm_ctrl_pkg::ERROR_BIT];
    end
  end

  // address pair: table accesses win over software; reset requests keep it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_low_reg <= 16'h0000;
      addr_up_reg  <= 8'h00;
    end
    else if (clk_en && !reset_req)
    begin
      if (tbl_wr_low || tbl_wr_high || tbl_rd)
      begin
        addr_low_reg <= tbl_addr[15:0];
        addr_up_reg  <= tbl_addr[23:16];
      end
      else if (reg_wr && reg_addr == nvm_ctrl_pkg::ADDR_LOW_OFS)
        addr_low_reg <= reg_wdata;
      else if (reg_wr && reg_addr == nvm_ctrl_pkg::ADDR_UP_OFS)
        addr_up_reg <= reg_wdata[7:0];
    end
  end

  // write latches: one slot per word, low word and high byte loaded apart
  genvar gi;
  generate
    for (gi = 0; gi < nvm_ctrl_pkg::LATCH_DEPTH; gi++)
    begin : g_latch
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          lat_low_reg[gi]  <= 16'h0000;
          lat_high_reg[gi] <= 8'h00;
        end
        else if (clk_en && tbl_index == 5'(gi))
        begin
          if (tbl_wr_low)
            lat_low_reg[gi] <= tbl_wdata;
          if (tbl_wr_high && !is_eeprom(tbl_addr))
            lat_high_reg[gi] <= tbl_wdata[7:0];
        end
      end
    end
  endgenerate

  // latch readout for the cell array, registered to keep the path short
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cell_data_reg <= 24'h000000;
    else if (clk_en)
      cell_data_reg <= {lat_high_reg[cell_latch_index], lat_low_reg[cell_latch_index]};
  end

  // one pulse per started cycle, with the aligned target and word count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cell_start_reg  <= 1'b0;
      cell_erase_reg  <= 1'b0;
      cell_eeprom_reg <= 1'b0;
      cell_addr_reg   <= 24'h000000;
      cell_count_reg  <= 6'h00;
    end
    else if (clk_en)
    begin
      cell_start_reg <= start_op;
      if (start_op)
      begin
        // the start write also loads op select, so take the fields from that write
        cell_erase_reg  <= reg_wdata[nvm_ctrl_pkg::OP_ERASE_BIT];
        cell_eeprom_reg <= reg_wdata[nvm_ctrl_pkg::OP_EEPROM_BIT];
        if (!reg_wdata[nvm_ctrl_pkg::OP_EEPROM_BIT])
        begin
          cell_addr_reg  <= {target[23:6], 6'h00};
          cell_count_reg <= nvm_ctrl_pkg::ROW_WORDS;
        end
        else if (reg_wdata[nvm_ctrl_pkg::OP_MULTI_BIT])
        begin
          cell_addr_reg  <= {target[23:5], 5'h00};
          cell_count_reg <= nvm_ctrl_pkg::BLOCK_WORDS;
        end
        else
        begin
          cell_addr_reg  <= {target[23:1], 1'b0};
          cell_count_reg <= nvm_ctrl_pkg::SINGLE_WORD;
        end
      end
    end
  end

  // cycle timer; the same count serves flash and eeprom cycles
  nvm_op_timer #(
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .start   (start_op),
    .abort   (reset_req),
    .busy    (op_busy),
    .done    (op_done)
  );

  // done flag: completion wins over a clear arriving in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      done_flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if (op_done)
        done_flag_reg <= 1'b1;
      else if (done_flag_clear)
        done_flag_reg <= 1'b0;
    end
  end

  // eeprom reads taken during a cycle are marked, not blocked
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      unreliable_reg <= 1'b0;
    else if (clk_en)
      unreliable_reg <= tbl_rd && is_eeprom(tbl_addr) && wr_reg;
  end

  // register read data, one cycle after the strobe; key and unmapped read zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= 16'h0000;
    else if (clk_en)
    begin
      rdata_reg <= 16'h0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          nvm_ctrl_pkg::ADDR_LOW_OFS: rdata_reg <= addr_low_reg;
          nvm_ctrl_pkg::ADDR_UP_OFS:  rdata_reg <= {8'h00, addr_up_reg};
          nvm_ctrl_pkg::CTRL_OFS:     rdata_reg <= {wr_reg, permit_reg, error_reg, 4'h0,
                                                    timing_reg, 1'b0, opsel_reg};
          default:                    rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  // stall only for flash cycles; eeprom cycles run in the background
  assign core_stall = wr_reg && !opsel_reg[nvm_ctrl_pkg::OP_EEPROM_BIT];

  assign reg_rdata           = rdata_reg;
  assign tbl_read_unreliable = unreliable_reg;
  assign nvm_done_flag       = done_flag_reg;
  assign cell_start          = cell_start_reg;
  assign cell_erase          = cell_erase_reg;
  assign cell_eeprom         = cell_eeprom_reg;
  assign cell_addr           = cell_addr_reg;
  assign cell_word_count     = cell_count_reg;
  assign cell_latch_data     = cell_data_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_start_keyed;
    $rose(wr_reg) |-> $past(key_state_reg == nvm_ctrl_pkg::KEY_ARMED && clk_en);
  endproperty
  a_start_keyed: assert property (p_start_keyed) else $error("start without keys");

  property p_permit_first;
    $rose(wr_reg) |-> $past(permit_reg);
  endproperty
  a_permit_first: assert property (p_permit_first) else $error("start without enable");

  // a reset request may legally cut the cycle short, so it ends the check
  property p_flash_stall;
    disable iff (!reset_n || reset_req)
    (clk_en && start_op && !reg_wdata[nvm_ctrl_pkg::OP_EEPROM_BIT]) |=> core_stall [*2];
  endproperty
  a_flash_stall: assert property (p_flash_stall) else $error("flash cycle not stalling");

  property p_ee_no_stall;
    (clk_en && start_op && reg_wdata[nvm_ctrl_pkg::OP_EEPROM_BIT]) |=> wr_reg && !core_stall;
  endproperty
  a_ee_no_stall: assert property (p_ee_no_stall) else $error("eeprom cycle stalls core");

  property p_wr_hw_clear;
    $fell(wr_reg) |-> $past((op_done || reset_req) && clk_en);
  endproperty
  a_wr_hw_clear: assert property (p_wr_hw_clear) else $error("start bit cleared early");

  property p_no_sw_clear;
    (clk_en && ctrl_wr && wr_reg && !op_done && !reset_req) |=> wr_reg;
  endproperty
  a_no_sw_clear: assert property (p_no_sw_clear) else $error("software cleared start");

  property p_done_sets;
    op_done |=> nvm_done_flag ##1 (nvm_done_flag || $past(done_flag_clear));
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag not set");

  property p_abort_err;
    (clk_en && reset_req && wr_reg) |=> error_reg && !wr_reg && $stable(target);
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("interrupted write unflagged");

  property p_high_byte;
    (clk_en && tbl_wr_high && !is_eeprom(tbl_addr))
      |=> lat_high_reg[$past(tbl_index)] == $past(tbl_wdata[7:0]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte latch wrong");

  property p_key_reads_zero;
    (clk_en && reg_rd && reg_addr == nvm_ctrl_pkg::KEY_OFS) |=> reg_rdata == 16'h0000;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");

  property p_row_size;
    (cell_start && !cell_eeprom) |-> cell_word_count == 6'h20 && cell_addr[5:0] == 6'h00;
  endproperty
  a_row_size: assert property (p_row_size) else $error("flash op not a row");

  c_flash_start: cover property (cell_start && !cell_eeprom);
  c_ee_block:    cover property (cell_start && cell_eeprom && cell_word_count == 6'h10);
  c_done:        cover property ($rose(nvm_done_flag));
  c_abort:       cover property ($rose(error_reg));

endmodule : nvm_program_erase_control
`default_nettype wire
